// file: rtl/rsc_reset_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "rsc_cfg.svh"

module rsc_reset_ctrl
    import rsc_pkg::*;
#(
    parameter int unsigned SOFT_DELAY_CYC = `RSC_SOFT_DELAY_CYC,
    parameter int unsigned FILTER_CYC = `RSC_FILTER_CYC,
    parameter int unsigned HOLD_CYC = `RSC_HOLD_CYC
) (
    // Clock and power-on reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // APB slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // Reset sources
    input wire logic supply_low_i,
    input wire logic sleep_idle_i,
    input wire logic wdog_timeout_i,
    input wire logic wdog_ctrl_bad_i,
    // Reset outputs, timeout flag and comparator control
    output logic sys_rst_n_o,
    output logic pc_sp_clear_o,
    output logic port_init_o,
    output logic timeout_status_flag_o,
    output logic brownout_enable_o,
    output logic [1:0] brownout_level_o
);

    localparam logic [15:0] SOFT_LOAD = 16'(SOFT_DELAY_CYC - 1);
    localparam logic [15:0] FILTER_LAST = 16'(FILTER_CYC);
    localparam logic [15:0] HOLD_LOAD = 16'(HOLD_CYC - 1);

    rsc_state_e state_r;
    logic [15:0] cnt_r;
    logic [15:0] filt_cnt_r;
    logic [7:0] reset_guard_r;
    logic [7:0] thresh_r;
    logic [3:0] cause_r;
    logic wdc_pend_r;
    logic flash_pend_r;
    logic low_meta_r;
    logic low_sync_r;

    // APB decode
    logic acc_phase;
    logic wr_en;
    logic addr_ok;
    logic [31:0] rd_data;

    // Reset triggers
    logic guard_bad;
    logic thr_bad;
    logic brown_trip;
    logic wdog_full;
    logic wdog_sleep;
    logic soft_done;
    logic enter_hold;
    logic [3:0] cause_set;

    assign acc_phase = psel_i & penable_i;
    assign wr_en = acc_phase & pready_o & pwrite_i;

    // Supply comparator is asynchronous to clk_i
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            low_meta_r <= 1'b0;
            low_sync_r <= 1'b0;
        end else begin
            low_meta_r <= supply_low_i;
            low_sync_r <= low_meta_r;
        end
    end

    assign guard_bad = (reset_guard_r != `RSC_GUARD_RST) &&
        (reset_guard_r != `RSC_GUARD_ALT);

    always_comb begin
        thr_bad = 1'b0;
        case (thresh_r)
            `RSC_THR_2V10, `RSC_THR_2V55,
            `RSC_THR_3V15, `RSC_THR_3V80: thr_bad = 1'b0;
            default: thr_bad = 1'b1;
        endcase
    end

    // Filter counts consecutive low cycles while detection is on
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            filt_cnt_r <= 16'h0000;
        end else if (!low_sync_r || sleep_idle_i ||
                     state_r == RSC_ST_HOLD) begin
            filt_cnt_r <= 16'h0000;
        end else if (filt_cnt_r != FILTER_LAST) begin
            filt_cnt_r <= filt_cnt_r + 16'h0001;
        end
    end

    // Trip only once the dip outlasts the filter time
    assign brown_trip = (filt_cnt_r == FILTER_LAST) && low_sync_r &&
        !sleep_idle_i && (state_r != RSC_ST_HOLD);

    assign wdog_full = wdog_timeout_i && !sleep_idle_i &&
        (state_r != RSC_ST_HOLD);
    assign wdog_sleep = wdog_timeout_i && sleep_idle_i;

    assign soft_done = (state_r == RSC_ST_DELAY) &&
        (cnt_r == 16'h0000);
    assign enter_hold = brown_trip || wdog_full || soft_done;

    always_comb begin
        cause_set = 4'h0;
        cause_set[`RSC_BIT_GUARD] = soft_done && guard_bad;
        cause_set[`RSC_BIT_BROWN] = brown_trip;
        cause_set[`RSC_BIT_THR] = soft_done && thr_bad;
        cause_set[`RSC_BIT_WDC] = soft_done && wdc_pend_r;
    end

    // Sequencer
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            state_r <= RSC_ST_HOLD;
            cnt_r <= HOLD_LOAD;
        end else begin
            case (state_r)
                RSC_ST_RUN: begin
                    if (enter_hold) begin
                        state_r <= RSC_ST_HOLD;
                        cnt_r <= HOLD_LOAD;
                    end else if (guard_bad || thr_bad || wdc_pend_r ||
                                 flash_pend_r) begin
                        state_r <= RSC_ST_DELAY;
                        cnt_r <= SOFT_LOAD;
                    end
                end
                RSC_ST_DELAY: begin
                    if (enter_hold) begin
                        state_r <= RSC_ST_HOLD;
                        cnt_r <= HOLD_LOAD;
                    end else begin
                        cnt_r <= cnt_r - 16'h0001;
                    end
                end
                RSC_ST_HOLD: begin
                    if (cnt_r == 16'h0000) begin
                        state_r <= RSC_ST_RUN;
                    end else begin
                        cnt_r <= cnt_r - 16'h0001;
                    end
                end
                default: begin
                    state_r <= RSC_ST_HOLD;
                    cnt_r <= HOLD_LOAD;
                end
            endcase
        end
    end

    // Pending soft requests; a new one in the hold cycle survives
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            wdc_pend_r <= 1'b0;
        end else if (wdog_ctrl_bad_i) begin
            wdc_pend_r <= 1'b1;
        end else if (enter_hold) begin
            wdc_pend_r <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            flash_pend_r <= 1'b0;
        end else if (wr_en && paddr_i == `RSC_OFF_FLASH1 &&
                     pwdata_i[7:0] == `RSC_FLASH_RST_CODE) begin
            flash_pend_r <= 1'b1;
        end else if (enter_hold) begin
            flash_pend_r <= 1'b0;
        end
    end

    // Guard register
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            reset_guard_r <= `RSC_GUARD_RST;
        end else if (enter_hold) begin
            reset_guard_r <= `RSC_GUARD_RST;
        end else if (wr_en && paddr_i == `RSC_OFF_GUARD) begin
            reset_guard_r <= pwdata_i[7:0];
        end
    end

    // Threshold register restored on awake watchdog timeout and bad-threshold reset, kept otherwise
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            thresh_r <= `RSC_THR_RST;
        end else if ((soft_done && thr_bad) || wdog_full) begin
            thresh_r <= `RSC_THR_RST;
        end else if (brown_trip) begin
            thresh_r <= thresh_r;
        end else if (wr_en && paddr_i == `RSC_OFF_THRESH) begin
            thresh_r <= pwdata_i[7:0];
        end
    end

    // Cause flags: hardware set wins over a software clear
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            cause_r <= 4'(`RSC_CAUSE_RST);
        end else if (wr_en && paddr_i == `RSC_OFF_CAUSE) begin
            cause_r <= (cause_r & pwdata_i[3:0]) |
                cause_set;
        end else begin
            cause_r <= cause_r | cause_set;
        end
    end

    // Timeout flag cleared only by power-on
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            timeout_status_flag_o <= 1'b0;
        end else if (wdog_full || wdog_sleep) begin
            timeout_status_flag_o <= 1'b1;
        end
    end

    // Reset outputs
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            sys_rst_n_o <= 1'b0;
            port_init_o <= 1'b1;
        end else begin
            sys_rst_n_o <= !(enter_hold ||
                (state_r == RSC_ST_HOLD && cnt_r != 16'h0000));
            port_init_o <= enter_hold ||
                (state_r == RSC_ST_HOLD && cnt_r != 16'h0000);
        end
    end

    // PC/SP clear covers full resets and the sleeping timeout
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            pc_sp_clear_o <= 1'b1;
        end else begin
            pc_sp_clear_o <= enter_hold || wdog_sleep ||
                (state_r == RSC_ST_HOLD &&
                 cnt_r != 16'h0000);
        end
    end

    // Comparator control
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            brownout_enable_o <= 1'b1;
            brownout_level_o <= RSC_LVL_2V10;
        end else begin
            brownout_enable_o <= !sleep_idle_i;
            case (thresh_r)
                `RSC_THR_2V55: brownout_level_o <= RSC_LVL_2V55;
                `RSC_THR_3V15: brownout_level_o <= RSC_LVL_3V15;
                `RSC_THR_3V80: brownout_level_o <= RSC_LVL_3V80;
                default: brownout_level_o <= RSC_LVL_2V10;
            endcase
        end
    end

    // Read mux
    always_comb begin
        rd_data = 32'h0000_0000;
        addr_ok = 1'b1;
        case (paddr_i)
            `RSC_OFF_GUARD: rd_data[7:0] = reset_guard_r;
            `RSC_OFF_CAUSE: rd_data[3:0] = cause_r;
            `RSC_OFF_THRESH: rd_data[7:0] = thresh_r;
            `RSC_OFF_FLASH1: rd_data = 32'h0000_0000;
            `RSC_OFF_STATUS:
                rd_data[`RSC_BIT_TO] = timeout_status_flag_o;
            default: addr_ok = 1'b0;
        endcase
    end

    // One wait state; data latched so it stands with pready
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            pready_o <= 1'b0;
            prdata_o <= 32'h0000_0000;
            pslverr_o <= 1'b0;
        end else begin
            pready_o <= acc_phase && !pready_o;
            if (acc_phase && !pready_o) begin
                prdata_o <= pwrite_i ? 32'h0000_0000 : rd_data;
                pslverr_o <= !addr_ok;
            end else begin
                prdata_o <= 32'h0000_0000;
                pslverr_o <= 1'b0;
            end
        end
    end

endmodule : rsc_reset_ctrl
`default_nettype wire

// file: rtl/rsc_cfg.svh
`ifndef RSC_CFG_SVH
`define RSC_CFG_SVH

// Register byte offsets
`define RSC_OFF_GUARD 8'h00
`define RSC_OFF_CAUSE 8'h04
`define RSC_OFF_THRESH 8'h08
`define RSC_OFF_FLASH1 8'h0c
`define RSC_OFF_STATUS 8'h10

// Guard codes
`define RSC_GUARD_RST 8'h55
`define RSC_GUARD_ALT 8'haa

// Threshold codes
`define RSC_THR_2V10 8'h55
`define RSC_THR_2V55 8'h33
`define RSC_THR_3V15 8'h99
`define RSC_THR_3V80 8'haa
`define RSC_THR_RST 8'h55

// Flash control one reset code
`define RSC_FLASH_RST_CODE 8'h55

// Cause flag bit positions
`define RSC_BIT_GUARD 3
`define RSC_BIT_BROWN 2
`define RSC_BIT_THR 1
`define RSC_BIT_WDC 0
`define RSC_CAUSE_RST 8'h00

// Status bit positions
`define RSC_BIT_TO 0

// Timing
`define RSC_CLK_MHZ 50
`define RSC_SOFT_DELAY_NS 16000
`define RSC_FILTER_NS 60000
`define RSC_SOFT_DELAY_CYC \
    ((`RSC_SOFT_DELAY_NS * `RSC_CLK_MHZ + 999) / 1000)
`define RSC_FILTER_CYC ((`RSC_FILTER_NS * `RSC_CLK_MHZ) / 1000)
`define RSC_HOLD_CYC 8

`endif

// file: rtl/rsc_pkg.sv
package rsc_pkg;

    typedef enum logic [2:0] {
        RSC_ST_RUN = 3'b001,
        RSC_ST_DELAY = 3'b010,
        RSC_ST_HOLD = 3'b100
    } rsc_state_e;

    typedef enum logic [1:0] {
        RSC_LVL_2V10 = 2'h0,
        RSC_LVL_2V55 = 2'h1,
        RSC_LVL_3V15 = 2'h2,
        RSC_LVL_3V80 = 2'h3
    } rsc_level_e;

endpackage : rsc_pkg

// file: testbench/rsc_reset_ctrl_checker.sv
`timescale 1ns/1ps
`default_nettype none
module rsc_reset_ctrl_checker #(
    parameter int unsigned HOLD_CYC = 8
) (
    // Clock, reset and bus
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] prdata_o,
    input wire logic pready_o,
    input wire logic pslverr_o,
    // Reset sources and results
    input wire logic sleep_idle_i,
    input wire logic wdog_timeout_i,
    input wire logic sys_rst_n_o,
    input wire logic pc_sp_clear_o,
    input wire logic timeout_status_flag_o,
    input wire logic brownout_enable_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    int unsigned low_cnt_r;
    logic ran_r;
    // Power-on hold is skipped: only triggered holds are measured
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            low_cnt_r <= 0;
            ran_r <= 1'b0;
        end else begin
            low_cnt_r <= sys_rst_n_o ? 0 : low_cnt_r + 1;
            ran_r <= ran_r | sys_rst_n_o;
        end
    end
    sequence s_acc;
        psel_i && penable_i && !pready_o;
    endsequence
    sequence s_wd_sleep;
        wdog_timeout_i && sleep_idle_i && sys_rst_n_o;
    endsequence
    property p_rdy_lat; s_acc |=> pready_o; endproperty
    a_rdy_lat: assert property (p_rdy_lat) else $error("no ready");
    property p_rdy_pulse; pready_o |=> !pready_o; endproperty
    a_rdy_pulse: assert property (p_rdy_pulse) else $error("long ready");
    property p_err; pslverr_o |-> pready_o; endproperty
    a_err: assert property (p_err) else $error("stray slverr");
    property p_cause_hi;
        pready_o && !pwrite_i && paddr_i == 8'h04 |-> prdata_o[31:4] == 0;
    endproperty
    a_cause_hi: assert property (p_cause_hi) else $error("cause high");
    property p_sleep_bo; sleep_idle_i |=> !brownout_enable_o; endproperty
    a_sleep_bo: assert property (p_sleep_bo) else $error("bo on");
    property p_wd_sleep;
        s_wd_sleep |=> (pc_sp_clear_o && sys_rst_n_o && timeout_status_flag_o)
            ##1 !pc_sp_clear_o;
    endproperty
    a_wd_sleep: assert property (p_wd_sleep) else $error("sleep wd");
    property p_wd_awake;
        wdog_timeout_i && !sleep_idle_i && sys_rst_n_o
            |=> !sys_rst_n_o && timeout_status_flag_o;
    endproperty
    a_wd_awake: assert property (p_wd_awake) else $error("awake wd");
    property p_hold; $rose(sys_rst_n_o) && ran_r |-> low_cnt_r == HOLD_CYC;
    endproperty
    a_hold: assert property (p_hold) else $error("hold length");
endmodule : rsc_reset_ctrl_checker
bind rsc_reset_ctrl rsc_reset_ctrl_checker #(.HOLD_CYC(HOLD_CYC)) u_chk (
    .clk_i, .rst_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .prdata_o,
    .pready_o, .pslverr_o, .sleep_idle_i, .wdog_timeout_i, .sys_rst_n_o,
    .pc_sp_clear_o, .timeout_status_flag_o, .brownout_enable_o);
`default_nettype wire

// file: testbench/tb_rsc_reset_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module tb_rsc_reset_ctrl;
    logic clk_i = 1'b0, rst_n_i = 1'b0, psel_i = 1'b0, penable_i = 1'b0;
    logic pwrite_i = 1'b0, supply_low_i = 1'b0, sleep_idle_i = 1'b0;
    logic wdog_timeout_i = 1'b0, wdog_ctrl_bad_i = 1'b0;
    logic [7:0] paddr_i = 8'h00;
    logic [31:0] pwdata_i = 32'h0, prdata_o, q;
    logic pready_o, pslverr_o, sys_rst_n_o, pc_sp_clear_o, port_init_o, e;
    logic timeout_status_flag_o, brownout_enable_o;
    logic [1:0] brownout_level_o;
    int error_cnt = 0, n_checks = 0;
    rsc_reset_ctrl #(.SOFT_DELAY_CYC(4), .FILTER_CYC(5), .HOLD_CYC(2)) dut (
        .clk_i, .rst_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
        .prdata_o, .pready_o, .pslverr_o, .supply_low_i, .sleep_idle_i,
        .wdog_timeout_i, .wdog_ctrl_bad_i, .sys_rst_n_o, .pc_sp_clear_o,
        .port_init_o, .timeout_status_flag_o, .brownout_enable_o,
        .brownout_level_o);
    always #10 clk_i = ~clk_i;
    task automatic chk(string nm, logic [31:0] x, logic [31:0] g);
        n_checks++;
        if (g !== x) begin
            error_cnt++;
            $display("unexpected %s exp %h got %h", nm, x, g);
        end
    endtask : chk
    task automatic finish_test;
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : finish_test
    task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
        int n;
        n = 0;
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        // Sample at the falling edge, where the registered answer is settled
        do begin
            @(negedge clk_i);
            n++;
        end while (pready_o !== 1'b1 && n < 20);
        q = prdata_o;
        e = pslverr_o;
        chk("pready", 32'h1, {31'h0, pready_o});
        // Request held through the rising edge that samples pready high
        @(posedge clk_i);
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        @(posedge clk_i);
    endtask : apb
    task automatic rd(logic [7:0] a, logic [31:0] x);
        apb(1'b0, a, 32'h0);
        chk("register", x, q);
    endtask : rd
    task automatic wlow(logic x);
        int n;
        n = 0;
        @(negedge clk_i);
        while (sys_rst_n_o === 1'b1 && n < 40) begin
            @(negedge clk_i);
            n++;
        end
        chk("reset seen", {31'h0, x}, {31'h0, n < 40});
        @(posedge clk_i);
    endtask : wlow
    task automatic whigh;
        int n;
        n = 0;
        @(negedge clk_i);
        while (sys_rst_n_o !== 1'b1 && n < 40) begin
            @(negedge clk_i);
            n++;
        end
        chk("reset release", 32'h1, {31'h0, sys_rst_n_o});
        @(posedge clk_i);
    endtask : whigh
    task automatic por;
        rst_n_i <= 1'b0;
        repeat (5) @(posedge clk_i);
        chk("pc clear", 32'h1, {31'h0, pc_sp_clear_o});
        chk("port init", 32'h1, {31'h0, port_init_o});
        rst_n_i <= 1'b1;
        @(posedge clk_i);
        whigh();
    endtask : por
    task automatic t_regs;
        logic [7:0] codes [4] = '{8'h55, 8'h33, 8'h99, 8'haa};
        rd(8'h00, 32'h55);
        rd(8'h08, 32'h55);
        rd(8'h04, 32'h0);
        apb(1'b0, 8'h14, 32'h0);
        chk("slverr", 32'h1, {31'h0, e});
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, 8'h08, {24'h0, codes[i]});
            // Level register follows the threshold one cycle later
            @(negedge clk_i);
            chk("level", i, {30'h0, brownout_level_o});
            @(posedge clk_i);
        end
        apb(1'b1, 8'h00, 32'haa);
        wlow(1'b0);
    endtask : t_regs
    task automatic t_soft;
        apb(1'b1, 8'h00, 32'h12);
        wlow(1'b1);
        whigh();
        rd(8'h04, 32'h8);
        rd(8'h00, 32'h55);
        apb(1'b1, 8'h04, 32'h0);
        rd(8'h04, 32'h0);
        apb(1'b1, 8'h08, 32'h12);
        wlow(1'b1);
        whigh();
        rd(8'h04, 32'h2);
        rd(8'h08, 32'h55);
        apb(1'b1, 8'h04, 32'h0);
        apb(1'b1, 8'h0c, 32'h55);
        wlow(1'b1);
        whigh();
    endtask : t_soft
    task automatic t_brown;
        apb(1'b1, 8'h08, 32'h99);
        supply_low_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        supply_low_i <= 1'b0;
        wlow(1'b0);
        sleep_idle_i <= 1'b1;
        supply_low_i <= 1'b1;
        wlow(1'b0);
        chk("bo enable", 32'h0, {31'h0, brownout_enable_o});
        supply_low_i <= 1'b0;
        sleep_idle_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        supply_low_i <= 1'b1;
        wlow(1'b1);
        supply_low_i <= 1'b0;
        whigh();
        rd(8'h04, 32'h4);
        rd(8'h08, 32'h99);
        apb(1'b1, 8'h04, 32'h0);
    endtask : t_brown
    task automatic t_wdog;
        wdog_ctrl_bad_i <= 1'b1;
        @(posedge clk_i);
        wdog_ctrl_bad_i <= 1'b0;
        wlow(1'b1);
        whigh();
        rd(8'h04, 32'h1);
        wdog_timeout_i <= 1'b1;
        @(posedge clk_i);
        wdog_timeout_i <= 1'b0;
        wlow(1'b1);
        whigh();
        chk("timeout", 32'h1, {31'h0, timeout_status_flag_o});
        por();
        sleep_idle_i <= 1'b1;
        wdog_timeout_i <= 1'b1;
        @(posedge clk_i);
        wdog_timeout_i <= 1'b0;
        wlow(1'b0);
        chk("timeout", 32'h1, {31'h0, timeout_status_flag_o});
        sleep_idle_i <= 1'b0;
    endtask : t_wdog
    initial begin
        por();
        t_regs();
        t_soft();
        t_brown();
        t_wdog();
        finish_test();
    end
    initial begin
        repeat (5000) @(posedge clk_i);
        error_cnt++;
        $display("unexpected run_time exp done got hang");
        finish_test();
    end
endmodule : tb_rsc_reset_ctrl
`default_nettype wire
